// >>> logic/egress_cos_sched.sv
// How it works
// - Four egress queues: high, med-high, med-low, low
// - Programmable map of eight 802.1p values
// - Scheduling off means plain round robin
// - Weighted mode applies weights and latency limit
// - Weights accepted only from one to sixteen
// - IPv4 with DiffServ enabled uses code point
// - Programmable map of sixty-four code points
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "sched_regs.svh"
module egress_cos_sched #(
  parameter int DATA_W = 32,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int unsigned MAX_LAT = `MAX_LAT_CYCLES
) (
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_IN_VALID,
  input wire logic [DATA_W-1:0] I_IN_DATA,
  input wire sched_pkg::class_tag_t I_IN_TAG,
  output logic O_IN_READY,
  output logic O_OUT_VALID,
  output logic [DATA_W-1:0] O_OUT_DATA,
  output sched_pkg::queue_t O_OUT_CLASS,
  input wire logic I_OUT_READY
);

  // ----------------------------------------------------------
  // Functions
  // ----------------------------------------------------------
  // Keep old weight unless new byte lies in 1..16
  function automatic logic [4:0] keep_w(input logic [4:0] old, input logic [7:0] b);
    return (b >= `WEIGHT_MIN && b <= `WEIGHT_MAX) ? b[4:0] : old;
  endfunction

  // First set bit below 'from', wrapping, 'from' itself last
  function automatic logic [1:0] next_below(input logic [1:0] from, input logic [3:0] m);
    logic [1:0] r;
    logic [1:0] c;
    r = from;
    for (int i = 4; i >= 1; i--) begin
      c = 2'(from - 2'(i));
      if (m[c]) begin
        r = c;
      end
    end
    return r;
  endfunction

  // Highest set bit
  function automatic logic [1:0] top_set(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (m[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------
  logic [1:0] rst_pipe; // Release synchroniser
  logic rst_n; // Internal reset

  // Assert at once, release after two edges
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ----------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------
  logic [1:0] ctrl; // Scheduling mode and DiffServ enable
  logic [31:0] weight; // Four weights, one per byte
  logic [15:0] pcp_map; // 802.1p to queue
  logic [127:0] dscp_map; // Code point to queue
  logic wrr_en; // Weighted mode
  logic dscp_en; // DiffServ mapping on
  logic setup; // Setup phase
  logic acc; // Completing access
  logic wr; // Write takes effect
  logic hit_ctrl;
  logic hit_weight;
  logic hit_pcp;
  logic hit_stat;
  logic hit_dscp;
  logic [31:0] rd_mux;
  logic [31:0] new_weight;
  logic [31:0] status;

  assign wrr_en = ctrl[`CTRL_WRR_BIT];
  assign dscp_en = ctrl[`CTRL_DSCP_BIT];
  assign setup = I_PSEL & ~I_PENABLE;
  assign acc = I_PSEL & I_PENABLE & O_PREADY;
  assign wr = acc & I_PWRITE;
  // Address decode
  assign hit_ctrl = (I_PADDR == `ADDR_CTRL);
  assign hit_weight = (I_PADDR == `ADDR_WEIGHT);
  assign hit_pcp = (I_PADDR == `ADDR_PCP_MAP);
  assign hit_stat = (I_PADDR == `ADDR_STATUS);
  assign hit_dscp = (I_PADDR[7:4] == `ADDR_DSCP_HI) & (I_PADDR[1:0] == 2'h0);
  // Out-of-range weight bytes leave that weight unchanged
  assign new_weight = {3'h0, keep_w(weight[28:24], I_PWDATA[31:24]),
                       3'h0, keep_w(weight[20:16], I_PWDATA[23:16]),
                       3'h0, keep_w(weight[12:8], I_PWDATA[15:8]),
                       3'h0, keep_w(weight[4:0], I_PWDATA[7:0])};
  // Read selection, unmapped reads zero
  assign rd_mux = hit_ctrl ? {30'h0, ctrl} :
                  hit_weight ? weight :
                  hit_pcp ? {16'h0, pcp_map} :
                  hit_stat ? status :
                  hit_dscp ? dscp_map[{I_PADDR[3:2], 5'h00} +: 32] : 32'h0;

  // Answer one cycle after setup: zero wait states
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= setup;
      O_PRDATA <= (setup & ~I_PWRITE) ? rd_mux : 32'h0;
      O_PSLVERR <= setup & ~(hit_ctrl | hit_weight | hit_pcp | hit_stat | hit_dscp);
    end
  end

  // Configuration writes land on the completing edge
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `RST_CTRL;
      weight <= `RST_WEIGHT;
      pcp_map <= `RST_PCP_MAP;
      dscp_map <= `RST_DSCP_MAP;
    end else if (wr) begin
      if (hit_ctrl) begin
        ctrl <= I_PWDATA[1:0];
      end
      if (hit_weight) begin
        weight <= new_weight;
      end
      if (hit_pcp) begin
        pcp_map <= I_PWDATA[15:0];
      end
      if (hit_dscp) begin
        dscp_map[{I_PADDR[3:2], 5'h00} +: 32] <= I_PWDATA;
      end
    end
  end

  // ----------------------------------------------------------
  // Classification stage
  // ----------------------------------------------------------
  logic stage_valid; // Frame waiting to enter a queue
  logic [1:0] stage_q; // Its queue
  logic [DATA_W-1:0] stage_data;
  logic [1:0] in_q; // Queue for the incoming frame
  logic take; // Frame accepted
  logic push; // Frame into its queue
  logic next_stage_valid;
  logic [3:0] q_in_ready;

  // IPv4 with DiffServ on uses code point, else 802.1p
  assign in_q = (dscp_en & I_IN_TAG.ipv4) ? dscp_map[{I_IN_TAG.dscp, 1'b0} +: 2]
                                          : pcp_map[{I_IN_TAG.pcp, 1'b0} +: 2];
  assign take = I_IN_VALID & O_IN_READY;
  assign push = stage_valid & q_in_ready[stage_q];
  assign next_stage_valid = take | (stage_valid & ~push);

  // One-entry stage; ready is registered so a full queue stalls the source
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      stage_valid <= 1'b0;
      stage_q <= 2'h0;
      O_IN_READY <= 1'b1;
    end else begin
      stage_valid <= next_stage_valid;
      stage_q <= take ? in_q : stage_q;
      O_IN_READY <= ~next_stage_valid;
    end
  end

  // Data copy, no reset needed
  always_ff @(posedge I_MCLK) begin
    if (take) begin
      stage_data <= I_IN_DATA;
    end
  end

  // ----------------------------------------------------------
  // Four queues
  // ----------------------------------------------------------
  logic [3:0] q_ov; // Queue has a head word
  logic [3:0] q_pop; // Queue drained this cycle
  logic [DATA_W-1:0] q_dout [4];

  for (genvar g = 0; g < 4; g++) begin : g_q
    // One FIFO per class
    queue_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(DEPTH)
    ) u_fifo (
      .clk(I_MCLK),
      .rst_n(rst_n),
      .i_valid(stage_valid & (stage_q == 2'(g))),
      .i_data(stage_data),
      .o_ready(q_in_ready[g]),
      .o_valid(q_ov[g]),
      .o_data(q_dout[g]),
      .i_ready(q_pop[g])
    );
  end

  // ----------------------------------------------------------
  // Scheduler
  // ----------------------------------------------------------
  logic [1:0] cur; // Queue last served
  logic [4:0] credit; // Packets sent from cur this round
  logic [31:0] age [4]; // Head wait time per queue
  logic [3:0] expired; // Head waited past the limit
  logic [4:0] cur_w; // Weight of cur
  logic stay; // Keep serving cur
  logic free; // Output register can take a word
  logic pop;
  logic [1:0] pick;

  for (genvar g = 0; g < 4; g++) begin : g_age
    assign expired[g] = q_ov[g] & (age[g] >= MAX_LAT);
    // Counts while a head waits; saturates to bound width use
    always_ff @(posedge I_MCLK or negedge rst_n) begin
      if (!rst_n) begin
        age[g] <= 32'h0;
      end else if (~q_ov[g] | q_pop[g]) begin
        age[g] <= 32'h0;
      end else if (age[g] < MAX_LAT) begin
        age[g] <= age[g] + 32'h1;
      end
    end
  end

  assign cur_w = weight[{cur, 3'h0} +: 5];
  assign free = ~O_OUT_VALID | I_OUT_READY;
  assign pop = free & (|q_ov);
  // Weights only count in weighted mode
  assign stay = wrr_en & q_ov[cur] & (credit < cur_w);
  // Overdue heads win in weighted mode; then cur while its weight lasts; otherwise rotate downward
  assign pick = (wrr_en & (|expired)) ? top_set(expired) :
                stay ? cur : next_below(cur, q_ov);
  assign q_pop = pop ? (4'h1 << pick) : 4'h0;

  // Round bookkeeping
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      cur <= 2'h3;
      credit <= 5'h00;
    end else if (pop) begin
      cur <= pick;
      // A new round starts unless cur keeps its turn; plain mode keeps no count
      credit <= (stay && (pick == cur)) ? 5'(credit + 5'h01) : (wrr_en ? 5'h01 : 5'h00);
    end
  end

  // Output register
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      O_OUT_VALID <= 1'b0;
      O_OUT_DATA <= '0;
      O_OUT_CLASS <= sched_pkg::Q_LOW;
    end else if (pop) begin
      O_OUT_VALID <= 1'b1;
      O_OUT_DATA <= q_dout[pick];
      O_OUT_CLASS <= sched_pkg::queue_t'(pick);
    end else if (I_OUT_READY) begin
      O_OUT_VALID <= 1'b0;
    end
  end

  assign status = {22'h0, cur, expired, q_ov};

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr(logic [7:0] a);
    I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && (I_PADDR == a);
  endsequence
  sequence s_stay;
    pop && wrr_en && !(|expired) && q_ov[cur] && (credit < cur_w);
  endsequence

  property p_push_lands;
    (push && (q_ov == 4'h0)) |-> ##[1:3] (q_ov != 4'h0);
  endproperty
  a_push_lands: assert property (p_push_lands)
    else $error("queued frame never reached a queue head");

  property p_pcp_class;
    (take && !(dscp_en && I_IN_TAG.ipv4) && !wr)
      |=> stage_q == pcp_map[{$past(I_IN_TAG.pcp), 1'b0} +: 2];
  endproperty
  a_pcp_class: assert property (p_pcp_class)
    else $error("802.1p frame in wrong queue");

  property p_rr_rotates;
    (pop && !wrr_en && ($countones(q_ov) > 1)) |=> cur != $past(cur);
  endproperty
  a_rr_rotates: assert property (p_rr_rotates)
    else $error("round robin served same queue twice");

  property p_overdue_first;
    (pop && wrr_en && expired[3]) |=> O_OUT_VALID && (O_OUT_CLASS == sched_pkg::Q_HIGH);
  endproperty
  a_overdue_first: assert property (p_overdue_first)
    else $error("overdue high queue not served");

  property p_weight_reject;
    s_wr(`ADDR_WEIGHT) ##0 ((I_PWDATA[7:0] == 8'h00) || (I_PWDATA[7:0] > `WEIGHT_MAX))
      |=> weight[4:0] == $past(weight[4:0]);
  endproperty
  a_weight_reject: assert property (p_weight_reject)
    else $error("out-of-range weight accepted");

  property p_dscp_class;
    (take && dscp_en && I_IN_TAG.ipv4 && !wr)
      |=> stage_q == dscp_map[{$past(I_IN_TAG.dscp), 1'b0} +: 2];
  endproperty
  a_dscp_class: assert property (p_dscp_class)
    else $error("DiffServ frame in wrong queue");

  property p_dscp_write;
    s_wr(8'h10) |=> dscp_map[31:0] == $past(I_PWDATA);
  endproperty
  a_dscp_write: assert property (p_dscp_write)
    else $error("code point map write lost");

  property p_wrr_stay;
    s_stay |=> (cur == $past(cur)) && (credit == 5'($past(credit) + 5'h01));
  endproperty
  a_wrr_stay: assert property (p_wrr_stay)
    else $error("queue left before using its weight");

  property p_credit_bound;
    wrr_en && (credit != 5'h00) |-> credit <= 5'h10;
  endproperty
  a_credit_bound: assert property (p_credit_bound)
    else $error("credit above largest weight");

endmodule

// >>> logic/queue_fifo.sv
`timescale 1ns/1ps
module queue_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);

  // ----------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH]; // Words behind the head register
  logic [AW-1:0] wptr; // Write pointer
  logic [AW-1:0] rptr; // Read pointer
  logic [AW:0] cnt; // Words held in mem
  logic push;
  logic load;
  logic [AW:0] next_cnt;

  // Honest full: refuse once mem holds DEPTH words
  assign o_ready = (cnt < (AW+1)'(DEPTH));
  assign push = i_valid & o_ready;
  // Refill head register when it is empty or being drained
  assign load = (cnt != '0) & (~o_valid | i_ready);
  assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(load);

  // Memory write, no reset on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= i_data;
    end
  end

  // Head register gives registered read data
  always_ff @(posedge clk) begin
    if (load) begin
      o_data <= mem[rptr];
    end
  end

  // Pointers and flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
      cnt <= '0;
      o_valid <= 1'b0;
    end else begin
      wptr <= push ? AW'(wptr + 1'b1) : wptr;
      rptr <= load ? AW'(rptr + 1'b1) : rptr;
      cnt <= next_cnt;
      o_valid <= load | (o_valid & ~i_ready);
    end
  end

endmodule

// >>> logic/sched_pkg.sv
package sched_pkg;

  // ----------------------------------------------------------
  // Egress queues, lowest first
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    Q_LOW = 2'h0,
    Q_MED_LOW = 2'h1,
    Q_MED_HIGH = 2'h2,
    Q_HIGH = 2'h3
  } queue_t;

  // ----------------------------------------------------------
  // Classification tag that rides with each frame
  // ----------------------------------------------------------
  typedef struct packed {
    logic ipv4;
    logic [5:0] dscp;
    logic [2:0] pcp;
  } class_tag_t;

endpackage

// >>> logic/sched_regs.svh
`ifndef SCHED_REGS_SVH
`define SCHED_REGS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_WEIGHT 8'h04
`define ADDR_PCP_MAP 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_DSCP_HI 4'h1

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CTRL_WRR_BIT 0
`define CTRL_DSCP_BIT 1
`define STAT_EXP_LSB 4
`define STAT_CUR_LSB 8

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define RST_CTRL 2'h0
`define RST_WEIGHT 32'h0F0A0401
`define RST_PCP_MAP 16'hFE90
`define RST_DSCP_MAP 128'h0
`define WEIGHT_MIN 8'h01
`define WEIGHT_MAX 8'h10

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_MHZ 10
`define MAX_LAT_US 400000
`define MAX_LAT_CYCLES (`MAX_LAT_US * `CLK_MHZ)
`define FIFO_DEPTH 32

`endif

// >>> verif/egress_sink.sv
`timescale 1ns/1ps
// ----------------------------------------
// Transmitter model at the egress side
// ----------------------------------------
module egress_sink #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  input wire sched_pkg::queue_t i_class,
  input wire logic i_hold,
  input wire logic i_slow,
  output logic o_ready
);
  sched_pkg::queue_t got_q[$]; // Classes in order of acceptance
  logic [W-1:0] got_d[$]; // Words in order of acceptance
  logic phase = 1'b0; // Half rate toggle for slow answers
  // ----------------------------------------
  // Accept and log; held or slow to stall the queues
  // ----------------------------------------
  always @(posedge clk) begin
    if (i_valid && o_ready) begin
      got_q.push_back(i_class);
      got_d.push_back(i_data);
    end
    phase <= ~phase;
    o_ready <= !i_hold && (!i_slow || phase);
  end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
`include "sched_regs.svh"
`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); \
  end \
end
module testbench;
  // ----------------------------------------
  // Clock, reset and port signals
  // ----------------------------------------
  logic I_MCLK = 1'b0;
  logic I_RSTN = 1'b0;
  logic I_PSEL = 1'b0;
  logic I_PENABLE = 1'b0;
  logic I_PWRITE = 1'b0;
  logic [7:0] I_PADDR = 8'h00;
  logic [31:0] I_PWDATA = 32'h0;
  logic [31:0] O_PRDATA;
  logic O_PREADY;
  logic O_PSLVERR;
  logic I_IN_VALID = 1'b0;
  logic [31:0] I_IN_DATA = 32'h0;
  sched_pkg::class_tag_t I_IN_TAG = '0;
  logic O_IN_READY;
  logic O_OUT_VALID;
  logic [31:0] O_OUT_DATA;
  sched_pkg::queue_t O_OUT_CLASS;
  logic I_OUT_READY;
  logic hold = 1'b1; // Stalls the transmitter model
  logic slow = 1'b0; // Half rate acceptance
  int mismatches = 0;
  int n_tests = 0;
  always #50 I_MCLK = ~I_MCLK;
  // Short latency limit keeps overdue service inside a short run
  egress_cos_sched #(.MAX_LAT(50)) i_egress_cos_sched (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_IN_VALID(I_IN_VALID), .I_IN_DATA(I_IN_DATA), .I_IN_TAG(I_IN_TAG),
    .O_IN_READY(O_IN_READY), .O_OUT_VALID(O_OUT_VALID), .O_OUT_DATA(O_OUT_DATA),
    .O_OUT_CLASS(O_OUT_CLASS), .I_OUT_READY(I_OUT_READY));
  egress_sink #(.W(32)) i_sink (.clk(I_MCLK), .i_valid(O_OUT_VALID), .i_data(O_OUT_DATA),
    .i_class(O_OUT_CLASS), .i_hold(hold), .i_slow(slow), .o_ready(I_OUT_READY));
  // ----------------------------------------
  // Bus and stream tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    I_PSEL <= 1'b1;
    I_PWRITE <= wr;
    I_PADDR <= a;
    I_PWDATA <= wd;
    @(posedge I_MCLK);
    I_PENABLE <= 1'b1;
    do begin
      @(posedge I_MCLK);
      n++;
    end while (O_PREADY !== 1'b1 && n < 20);
    if (O_PREADY !== 1'b1)
      mismatches++;
    rd = O_PRDATA;
    err = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
    // Idle edge so the next call never reassigns psel in this time step
    @(posedge I_MCLK);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic e_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    `CHK("read data", e, rd)
    `CHK("slave error", e_err, err)
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic e_err);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    `CHK("write error", e_err, err)
  endtask
  // Offers one word; ok is low when the stage kept refusing
  task automatic push(input logic ip, input logic [5:0] ds, input logic [2:0] pc,
                      input logic [31:0] d, output bit ok);
    int n;
    n = 0;
    I_IN_VALID <= 1'b1;
    I_IN_DATA <= d;
    I_IN_TAG <= '{ipv4: ip, dscp: ds, pcp: pc};
    do begin
      @(posedge I_MCLK);
      n++;
    end while (O_IN_READY !== 1'b1 && n < 30);
    ok = (O_IN_READY === 1'b1);
    I_IN_VALID <= 1'b0;
    I_IN_DATA <= ~d; // Stale data never looks valid
    @(posedge I_MCLK);
  endtask
  task automatic drain(input int n);
    int k;
    k = 0;
    hold <= 1'b0;
    while (i_sink.got_q.size() < n && k < 400) begin
      @(posedge I_MCLK);
      k++;
    end
    `CHK("words out", n, i_sink.got_q.size())
  endtask
  // Sends one word and checks the queue it leaves by
  task automatic one(input logic ip, input logic [5:0] ds, input logic [2:0] pc,
                     input logic [1:0] e);
    bit ok;
    i_sink.got_q.delete();
    push(ip, ds, pc, 32'hA5, ok);
    drain(1);
    `CHK("queue", e, 2'(i_sink.got_q[0]))
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rchk(`ADDR_CTRL, 32'h0, 1'b0);
    rchk(`ADDR_WEIGHT, `RST_WEIGHT, 1'b0);
    rchk(`ADDR_PCP_MAP, 32'(`RST_PCP_MAP), 1'b0);
    rchk(8'h20, 32'h0, 1'b1);
    wchk(8'h24, 32'hFFFFFFFF, 1'b1);
    // Zero and seventeen refused per byte, the rest land
    wchk(`ADDR_WEIGHT, 32'h11000405, 1'b0);
    rchk(`ADDR_WEIGHT, 32'h0F0A0405, 1'b0);
    wchk(`ADDR_WEIGHT, 32'h10080201, 1'b0);
    rchk(`ADDR_WEIGHT, 32'h10080201, 1'b0);
  endtask
  task automatic t_maps();
    slow <= 1'b1;
    for (int p = 0; p < 8; p++)
      one(1'b0, 6'h0, 3'(p), 2'(`RST_PCP_MAP >> (2 * p)));
    wchk(8'h14, 32'h00000300, 1'b0);
    wchk(8'h1C, 32'h80000000, 1'b0);
    wchk(`ADDR_CTRL, 32'h2, 1'b0);
    one(1'b1, 6'd20, 3'd7, 2'h3);
    one(1'b1, 6'd63, 3'd7, 2'h2);
    one(1'b1, 6'd21, 3'd7, 2'h0);
    one(1'b0, 6'd20, 3'd0, 2'h0);
    slow <= 1'b0;
  endtask
  // Five high and two low words queued behind a stalled transmitter
  task automatic t_sched(input logic wrr, input logic [13:0] e);
    bit ok;
    wchk(`ADDR_CTRL, {31'h0, wrr}, 1'b0);
    wchk(`ADDR_WEIGHT, 32'h04030201, 1'b0);
    hold <= 1'b1;
    i_sink.got_q.delete();
    for (int i = 0; i < 7; i++)
      push(1'b0, 6'h0, (i < 5) ? 3'd7 : 3'd0, 32'(i), ok);
    drain(7);
    for (int i = 0; i < 7; i++)
      `CHK("served queue", e[13 - 2 * i -: 2], 2'(i_sink.got_q[i]))
  endtask
  // Old low head overtakes fresh high words in weighted mode
  task automatic t_overdue();
    bit ok;
    hold <= 1'b1;
    i_sink.got_q.delete();
    push(1'b0, 6'h0, 3'd0, 32'h10, ok);
    push(1'b0, 6'h0, 3'd0, 32'h11, ok);
    repeat (60) @(posedge I_MCLK);
    push(1'b0, 6'h0, 3'd7, 32'h12, ok);
    push(1'b0, 6'h0, 3'd7, 32'h13, ok);
    drain(4);
    for (int i = 0; i < 4; i++)
      `CHK("overdue order", (i < 2) ? 2'h0 : 2'h3, 2'(i_sink.got_q[i]))
  endtask
  task automatic t_fill();
    bit ok;
    int cnt;
    cnt = 0;
    ok = 1'b1;
    wchk(`ADDR_CTRL, 32'h0, 1'b0);
    hold <= 1'b1;
    i_sink.got_d.delete();
    i_sink.got_q.delete();
    while (ok && cnt < 40) begin
      push(1'b0, 6'h0, 3'd3, 32'(cnt), ok);
      cnt += int'(ok);
    end
    // Memory words plus head, stage and output registers
    `CHK("fill", `FIFO_DEPTH + 3, cnt)
    drain(cnt);
    for (int i = 0; i < cnt; i++)
      `CHK("word order", 32'(i), i_sink.got_d[i])
  endtask
  // ----------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------
  task automatic finish_test();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge I_MCLK);
    I_RSTN <= 1'b1;
    repeat (3) @(posedge I_MCLK);
    t_regs();
    t_maps();
    t_sched(1'b0, 14'b11_00_11_00_11_11_11);
    rchk(`ADDR_STATUS, 32'h00000300, 1'b0);
    t_sched(1'b1, 14'b11_11_11_11_00_11_00);
    t_overdue();
    t_fill();
    finish_test();
  end
  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge I_MCLK);
    mismatches++;
    finish_test();
  end
endmodule
